// ===== src/dwb_write_burst.v
`timescale 1ns/1ps
`include "dwb_consts.vh"
module dwb_write_burst (
    input  wire                     clk,
    input  wire                     resetn,
    input  wire [`DWB_CMD_W-1:0]    cmd,
    input  wire [`DWB_BANK_W-1:0]   bank,
    input  wire [`DWB_ADDR_W-1:0]   addr,
    input  wire                     mode_bl8,
    input  wire [`DWB_CL_W-1:0]     mode_cl,
    input  wire [`DWB_CL_W-1:0]     mode_al,
    input  wire [`DWB_WR_W-1:0]     mode_wr,
    input  wire                     ck_pin,
    input  wire                     ldqs_pin,
    input  wire                     udqs_pin,
    input  wire [`DWB_DQ_W-1:0]     dq_pin,
    input  wire [1:0]               dm_pin,
    output wire [`DWB_DQ_W-1:0]     dq_out,
    output wire [`DWB_DQ_W-1:0]     dq_oe,
    output reg  [`DWB_DQ_W-1:0]     wdata_reg,
    output reg  [1:0]               wmask_reg,
    output reg                      wvalid_reg,
    output reg                      wlast_reg,
    output reg  [`DWB_BANK_W-1:0]   wbank_reg,
    output reg                      busy_reg,
    output reg                      autopre_reg,
    output reg  [`DWB_BANK_W-1:0]   autopre_bank_reg
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_RECV = 2'h3;

    // Outputs of the write port never drive the data pins
    assign dq_out = {`DWB_DQ_W{1'b0}};
    assign dq_oe  = {`DWB_DQ_W{1'b0}};

    wire [`DWB_DQ_W-1:0] dq_s;
    wire [1:0]           dm_s;
    wire                 ck_s;
    wire                 ldqs_s;
    wire                 udqs_s;
    wire                 ck_rise;
    wire                 ldqs_rise;
    wire                 ldqs_fall;
    wire                 udqs_rise;
    wire                 udqs_fall;

    dwb_sync2 #(.W(`DWB_DQ_W + 5)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .d      ({dq_pin, dm_pin, ck_pin, ldqs_pin, udqs_pin}),
        .q      ({dq_s, dm_s, ck_s, ldqs_s, udqs_s})
    );
    dwb_edge u_ck (
        .clk    (clk),
        .resetn (resetn),
        .level  (ck_s),
        .rise   (ck_rise),
        .fall   ()
    );
    dwb_edge u_ldqs (
        .clk    (clk),
        .resetn (resetn),
        .level  (ldqs_s),
        .rise   (ldqs_rise),
        .fall   (ldqs_fall)
    );
    dwb_edge u_udqs (
        .clk    (clk),
        .resetn (resetn),
        .level  (udqs_s),
        .rise   (udqs_rise),
        .fall   (udqs_fall)
    );

    // Data delayed to line up with the edge detector output
    reg [`DWB_DQ_W-1:0] dq_d_reg;
    reg [1:0]           dm_d_reg;
    always @(posedge clk) begin
        if (!resetn) begin
            dq_d_reg <= {`DWB_DQ_W{1'b0}};
            dm_d_reg <= 2'h0;
        end else begin
            dq_d_reg <= dq_s;
            dm_d_reg <= dm_s;
        end
    end

    // Commands are sampled on link clock rising edges
    wire cmd_write = ck_rise && (cmd == `DWB_CMD_WRITE);

    reg [1:0]               state_reg;
    reg [1:0]               state_next;
    reg [`DWB_CNT_W-1:0]    wl_cnt_reg;
    reg [`DWB_CNT_W-1:0]    wl_cnt_next;
    reg [3:0]               elem_reg;
    reg [3:0]               elem_next;
    reg [3:0]               nelem_reg;
    reg [3:0]               nelem_next;
    reg [`DWB_CNT_W-1:0]    rec_cnt_reg;
    reg [`DWB_CNT_W-1:0]    rec_cnt_next;
    reg                     ap_reg;
    reg                     ap_next;
    reg [`DWB_BANK_W-1:0]   bank_reg;
    reg [`DWB_BANK_W-1:0]   bank_next;
    reg [2:0]               since_reg;
    reg [2:0]               since_next;
    reg                     pend_reg;
    reg                     pend_next;
    reg                     pend_ap_reg;
    reg                     pend_ap_next;
    reg [`DWB_BANK_W-1:0]   pend_bank_reg;
    reg [`DWB_BANK_W-1:0]   pend_bank_next;
    reg                     lo_hit;
    reg                     hi_hit;

    // Write latency: additive plus CAS latency, less one
    function [`DWB_CNT_W-1:0] wl_cycles;
        input [`DWB_CL_W-1:0] al;
        input [`DWB_CL_W-1:0] cl;
        reg   [`DWB_CNT_W-1:0] s;
        begin
            s = {3'h0, al} + {3'h0, cl} - `DWB_WL_MIN;
            if (s == {`DWB_CNT_W{1'b0}})
                s = `DWB_WL_MIN;
            wl_cycles = s;
        end
    endfunction

    function [3:0] burst_len;
        input bl8;
        begin
            burst_len = bl8 ? 4'h8 : 4'h4;
        end
    endfunction

    always @* begin
        state_next     = state_reg;
        wl_cnt_next    = wl_cnt_reg;
        elem_next      = elem_reg;
        nelem_next     = nelem_reg;
        rec_cnt_next   = rec_cnt_reg;
        ap_next        = ap_reg;
        bank_next      = bank_reg;
        since_next     = since_reg;
        pend_next      = pend_reg;
        pend_ap_next   = pend_ap_reg;
        pend_bank_next = pend_bank_reg;
        lo_hit         = ldqs_rise | ldqs_fall;
        hi_hit         = udqs_rise | udqs_fall;
        if (ck_rise && since_reg != 3'h7)
            since_next = since_reg + 3'h1;
        case (state_reg)
            ST_IDLE, ST_RECV: begin
                if (state_reg == ST_RECV && ck_rise) begin
                    if (rec_cnt_reg != {`DWB_CNT_W{1'b0}})
                        rec_cnt_next = rec_cnt_reg - 1'b1;
                    else
                        state_next = ST_IDLE;
                end
                if (cmd_write) begin
                    state_next  = ST_WAIT;
                    wl_cnt_next = wl_cycles(mode_al, mode_cl);
                    elem_next   = 4'h0;
                    nelem_next  = burst_len(mode_bl8);
                    ap_next     = addr[`DWB_AP_BIT];
                    bank_next   = bank;
                    since_next  = 3'h0;
                end
            end
            ST_WAIT: begin
                if (ck_rise && wl_cnt_reg != {`DWB_CNT_W{1'b0}})
                    wl_cnt_next = wl_cnt_reg - 1'b1;
                // Preamble: falling edges before first rise are ignored
                if (ldqs_rise) begin
                    state_next = ST_DATA;
                    elem_next  = 4'h1;
                end
            end
            default: begin
                if (lo_hit)
                    elem_next = elem_reg + 4'h1;
                if (lo_hit && elem_reg + 4'h1 == nelem_reg) begin
                    state_next   = ST_RECV;
                    rec_cnt_next = {3'h0, mode_wr};
                end
            end
        endcase
        // Follow-on write: gapless or truncating
        if (cmd_write && state_reg != ST_IDLE && state_reg != ST_RECV) begin
            pend_next      = 1'b1;
            pend_ap_next   = addr[`DWB_AP_BIT];
            pend_bank_next = bank;
            if (nelem_reg == 4'h8 && since_reg == 3'h1 && !ap_reg)
                nelem_next = 4'h4;
        end
        if (state_next == ST_RECV && pend_reg) begin
            // Next burst's preamble was the tail of this one
            state_next  = ST_DATA;
            elem_next   = 4'h0;
            nelem_next  = burst_len(mode_bl8);
            ap_next     = pend_ap_reg;
            bank_next   = pend_bank_reg;
            pend_next   = 1'b0;
            since_next  = 3'h0;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            state_reg     <= ST_IDLE;
            wl_cnt_reg    <= {`DWB_CNT_W{1'b0}};
            elem_reg      <= 4'h0;
            nelem_reg     <= 4'h4;
            rec_cnt_reg   <= {`DWB_CNT_W{1'b0}};
            ap_reg        <= 1'b0;
            bank_reg      <= {`DWB_BANK_W{1'b0}};
            since_reg     <= 3'h7;
            pend_reg      <= 1'b0;
            pend_ap_reg   <= 1'b0;
            pend_bank_reg <= {`DWB_BANK_W{1'b0}};
        end else begin
            state_reg     <= state_next;
            wl_cnt_reg    <= wl_cnt_next;
            elem_reg      <= elem_next;
            nelem_reg     <= nelem_next;
            rec_cnt_reg   <= rec_cnt_next;
            ap_reg        <= ap_next;
            bank_reg      <= bank_next;
            since_reg     <= since_next;
            pend_reg      <= pend_next;
            pend_ap_reg   <= pend_ap_next;
            pend_bank_reg <= pend_bank_next;
        end
    end

    // Capture: each strobe lane owns its byte
    wire capture = (state_reg == ST_DATA) ||
                   (state_reg == ST_WAIT && ldqs_rise);
    always @(posedge clk) begin
        if (!resetn) begin
            wdata_reg  <= {`DWB_DQ_W{1'b0}};
            wmask_reg  <= 2'h0;
            wvalid_reg <= 1'b0;
            wlast_reg  <= 1'b0;
            wbank_reg  <= {`DWB_BANK_W{1'b0}};
        end else begin
            wvalid_reg <= capture && lo_hit;
            wlast_reg  <= capture && lo_hit &&
                          (elem_reg + 4'h1 == nelem_reg);
            wbank_reg  <= bank_reg;
            if (capture && lo_hit) begin
                wdata_reg[7:0] <= dq_d_reg[7:0];
                wmask_reg[0]   <= dm_d_reg[0];
            end
            if (capture && hi_hit) begin
                wdata_reg[15:8] <= dq_d_reg[15:8];
                wmask_reg[1]    <= dm_d_reg[1];
            end
        end
    end

    // A burst chained into the next one skips ST_RECV, so its own
    // auto precharge is timed here. Limitation: a clash with the main
    // recovery firing in the same cycle keeps only this one.
    wire                    chain = pend_reg && !pend_next;
    reg                     held_ap_reg;
    reg [`DWB_CNT_W-1:0]    held_cnt_reg;
    reg [`DWB_BANK_W-1:0]   held_bank_reg;
    always @(posedge clk) begin
        if (!resetn) begin
            held_ap_reg   <= 1'b0;
            held_cnt_reg  <= {`DWB_CNT_W{1'b0}};
            held_bank_reg <= {`DWB_BANK_W{1'b0}};
        end else if (chain && ap_reg) begin
            held_ap_reg   <= 1'b1;
            held_cnt_reg  <= {3'h0, mode_wr};
            held_bank_reg <= bank_reg;
        end else if (held_ap_reg && ck_rise) begin
            if (held_cnt_reg != {`DWB_CNT_W{1'b0}})
                held_cnt_reg <= held_cnt_reg - 1'b1;
            else
                held_ap_reg <= 1'b0;
        end
    end
    wire held_fire = held_ap_reg && ck_rise &&
                     (held_cnt_reg == {`DWB_CNT_W{1'b0}});

    // Auto precharge fires when recovery ends; masks do not matter
    always @(posedge clk) begin
        if (!resetn) begin
            busy_reg         <= 1'b0;
            autopre_reg      <= 1'b0;
            autopre_bank_reg <= {`DWB_BANK_W{1'b0}};
        end else begin
            busy_reg    <= (state_next != ST_IDLE);
            autopre_reg <= held_fire ||
                           ((state_reg == ST_RECV) && ck_rise &&
                            (rec_cnt_reg == {`DWB_CNT_W{1'b0}}) &&
                            ap_reg);
            if (held_fire)
                autopre_bank_reg <= held_bank_reg;
            else if (state_reg == ST_RECV && ck_rise)
                autopre_bank_reg <= bank_reg;
        end
    end
endmodule

// ===== src/dwb_consts.vh
`ifndef DWB_CONSTS_VH
`define DWB_CONSTS_VH
// Command encodings on the decoded command port
`define DWB_CMD_W        3
`define DWB_CMD_NOP      3'h0
`define DWB_CMD_WRITE    3'h1
`define DWB_CMD_READ     3'h2
`define DWB_CMD_PRE      3'h3
`define DWB_CMD_ACT      3'h4
// Mode fields
`define DWB_BL8_BIT      0
`define DWB_CL_W         3
`define DWB_CL_RST       3'h3
`define DWB_AL_RST       3'h0
`define DWB_WR_W         3
`define DWB_WR_RST       3'h2
`define DWB_BANK_W       3
`define DWB_NBANK        8
`define DWB_AP_BIT       10
`define DWB_ADDR_W       14
`define DWB_DQ_W         16
`define DWB_CNT_W        6
`define DWB_WL_MIN       6'h01
`endif

// ===== src/dwb_sync2.v
`timescale 1ns/1ps
module dwb_sync2 #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         resetn,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_reg;
    always @(posedge clk) begin
        if (!resetn) begin
            meta_reg <= {W{1'b0}};
            q        <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule

// ===== src/dwb_edge.v
`timescale 1ns/1ps
module dwb_edge (
    input  wire clk,
    input  wire resetn,
    input  wire level,
    output reg  rise,
    output reg  fall
);
    reg last_reg;
    always @(posedge clk) begin
        if (!resetn) begin
            last_reg <= 1'b0;
            rise     <= 1'b0;
            fall     <= 1'b0;
        end else begin
            last_reg <= level;
            rise     <= level & ~last_reg;
            fall     <= ~level & last_reg;
        end
    end
endmodule

// ===== tb/dwb_wb_monitor.sv
`timescale 1ns/1ps
`include "dwb_consts.vh"
module dwb_wb_monitor (
    input wire                 clk,
    input wire                 resetn,
    input wire [`DWB_DQ_W-1:0] dq_out,
    input wire [`DWB_DQ_W-1:0] dq_oe,
    input wire [`DWB_DQ_W-1:0] wdata_reg,
    input wire [1:0]           wmask_reg,
    input wire                 wvalid_reg,
    input wire                 wlast_reg,
    input wire                 busy_reg,
    input wire                 autopre_reg
);
    logic last_seen;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Two, not three: strobe sync may slip one clk
    sequence no_data2; !wvalid_reg [*2]; endsequence
    always @(posedge clk) begin
        if (!resetn)
            last_seen <= 1'b0;
        else if (wlast_reg)
            last_seen <= 1'b1;
    end
    pins_released_a: assert property (~|{dq_oe, dq_out})
        else $error("data pins driven");
    last_is_data_a: assert property (wlast_reg |-> wvalid_reg)
        else $error("last flag without element");
    element_gap_a: assert property (wvalid_reg |=> no_data2)
        else $error("elements closer than strobe edges");
    hold_element_a: assert property (
        !wvalid_reg |-> $stable({wmask_reg, wdata_reg}))
        else $error("element changed between strobes");
    busy_burst_a: assert property (wvalid_reg |-> busy_reg)
        else $error("element outside burst");
    first_delay_a: assert property ($rose(busy_reg) |=> no_data2)
        else $error("element before write latency");
    precharge_pulse_a: assert property (autopre_reg |=> !autopre_reg)
        else $error("precharge pulse too long");
    precharge_late_a: assert property (autopre_reg |-> last_seen)
        else $error("precharge before burst end");
endmodule
bind dwb_write_burst dwb_wb_monitor u_mon (
    .clk(clk), .resetn(resetn), .dq_out(dq_out), .dq_oe(dq_oe),
    .wdata_reg(wdata_reg), .wmask_reg(wmask_reg),
    .wvalid_reg(wvalid_reg), .wlast_reg(wlast_reg),
    .busy_reg(busy_reg), .autopre_reg(autopre_reg));

// ===== tb/dwb_ctl_model.sv
`timescale 1ns/1ps
`include "dwb_consts.vh"
module dwb_ctl_model (
    output logic                   ck,
    output logic [`DWB_CMD_W-1:0]  cmd,
    output logic [`DWB_BANK_W-1:0] bank,
    output logic [`DWB_ADDR_W-1:0] addr,
    output logic                   dqs,
    output logic [`DWB_DQ_W-1:0]   dq,
    output logic [1:0]             dm
);
    logic [`DWB_CMD_W-1:0]  c_cmd [0:31];
    logic [`DWB_BANK_W-1:0] c_bank[0:31];
    logic                   c_ap  [0:31];
    logic [1:0]             s_on  [0:31];
    logic [35:0]            s_dat [0:31];
    initial begin
        {ck, cmd, bank, addr, dqs, dq, dm} = '0;
        // Odd offset keeps the link clock out of phase with clk
        #137;
        forever #400 ck = ~ck;
    end
    // Idle slots put inverted data on the pins, never a held value
    task automatic run(input int n);
        @(negedge ck);
        for (int j = 0; j < n; j++) begin
            cmd <= c_cmd[j];
            bank <= c_bank[j];
            addr <= {3'h0, c_ap[j], 10'h000};
            #200 {dm, dq} <= s_on[j] == 2'h1 ? s_dat[j][35:18] : ~{dm, dq};
            #200 dqs <= s_on[j] != 2'h0;
            #200 {dm, dq} <= s_on[j] == 2'h1 ? s_dat[j][17:0] : ~{dm, dq};
            #200 dqs <= 1'b0;
        end
    endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "dwb_consts.vh"
module tb;
    logic                  clk = 1'b0;
    logic                  resetn = 1'b0;
    logic                  bl8 = 1'b0;
    logic [`DWB_CL_W-1:0]  al = 3'h0;
    wire                   ck, dqs, wvalid, wlast, busy, ap;
    wire [`DWB_CMD_W-1:0]  cmd;
    wire [`DWB_BANK_W-1:0] bnk, wbank, apb;
    wire [`DWB_ADDR_W-1:0] addr;
    wire [`DWB_DQ_W-1:0]   dq, wdata;
    wire [1:0]             dm, wmask;
    int                    failures = 0;
    int                    n_compared = 0;
    int                    seed = 32'hFFC9;
    logic                  lst;
    logic [20:0]           ex;
    logic [20:0]           exq[$];
    logic [2:0]            apq[$];

    always #50 clk = ~clk;

    dwb_ctl_model ctl (.ck(ck), .cmd(cmd), .bank(bnk), .addr(addr),
                       .dqs(dqs), .dq(dq), .dm(dm));
    dwb_write_burst DUT (
        .clk(clk), .resetn(resetn), .cmd(cmd), .bank(bnk), .addr(addr),
        .mode_bl8(bl8), .mode_cl(3'h3), .mode_al(al), .mode_wr(3'h2),
        .ck_pin(ck), .ldqs_pin(dqs), .udqs_pin(dqs), .dq_pin(dq),
        .dm_pin(dm), .dq_out(), .dq_oe(), .wdata_reg(wdata),
        .wmask_reg(wmask), .wvalid_reg(wvalid), .wlast_reg(wlast),
        .wbank_reg(wbank), .busy_reg(busy), .autopre_reg(ap),
        .autopre_bank_reg(apb));

    task automatic chk(input logic [20:0] got, exp, input string m);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(negedge clk) begin
        if (wvalid === 1'b1) begin
            lst = exq.size() == 1;
            ex = exq.size() > 0 ? exq.pop_front() : 'x;
            chk({wmask, wdata}, ex, "data");
            if (lst) chk(wlast, 1'b1, "last");
        end
        if (ap === 1'b1) begin
            ex = apq.size() > 0 ? apq.pop_front() : 'x;
            chk(apb, ex, "precharge bank");
        end
    end

    task automatic scen(input bit b8, input logic [2:0] a, input int off,
                        input bit ap1, ap2, stray);
        int                     k, wl, bl2;
        logic [`DWB_BANK_W-1:0] bk;
        @(posedge clk);
        bl8 <= b8;
        al <= a;
        wl = a + 2;
        bl2 = b8 ? 4 : 2;
        for (int j = 0; j < 32; j++) begin
            ctl.c_cmd[j] = `DWB_CMD_NOP;
            ctl.c_bank[j] = 3'h0;
            ctl.c_ap[j] = 1'b0;
            ctl.s_on[j] = 2'h0;
        end
        for (int w = 0; w < 2; w++) begin
            if (w == 0 || off > 0) begin
                k = w ? 1 + off : 1;
                bk = w ? bk ^ 3'h5 : 3'($random(seed));
                ctl.c_cmd[k] = `DWB_CMD_WRITE;
                ctl.c_bank[k] = bk;
                ctl.c_ap[k] = w ? ap2 : ap1;
                if (w ? ap2 : ap1) apq.push_back(bk);
                for (int e = 0; e < bl2; e++) begin
                    ctl.s_on[k + wl + e] = 2'h1;
                    ctl.s_dat[k + wl + e] = 36'({$random(seed), $random(seed)});
                end
            end
        end
        if (stray) ctl.s_on[28] = 2'h2;
        for (int j = 0; j < 32; j++)
            if (ctl.s_on[j] == 2'h1) begin
                exq.push_back(ctl.s_dat[j][35:18]);
                exq.push_back(ctl.s_dat[j][17:0]);
            end
        repeat (8) @(posedge clk);
        ctl.run(30);
        for (int t = 0; t < 400 && exq.size() > 0; t++) @(posedge clk);
        if (exq.size() > 0) begin
            failures++;
            tally_and_finish;
        end
        repeat (40) @(posedge clk);
        chk(apq.size(), 0, "missing precharge");
        chk(busy, 1'b0, "busy after burst");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        scen(1'b0, 3'h0, 0, 1'b0, 1'b0, 1'b1);
        scen(1'b0, 3'h0, 2, 1'b0, 1'b1, 1'b0);
        scen(1'b1, 3'h0, 2, 1'b0, 1'b1, 1'b0);
        scen(1'b1, 3'h1, 4, 1'b1, 1'b0, 1'b0);
        scen(1'b0, 3'h1, 0, 1'b1, 1'b0, 1'b1);
        tally_and_finish;
    end
endmodule
